// ===== sgeb_elastic.sv
// receive elastic buffer: link-sampled write side, core-paced read side
`timescale 1ns/100ps
module sgeb_elastic
    import sgeb_pkg::*;
#(
    parameter bit USE_SMALL = 1'b0 // 1 selects the 64-entry variant
)
(
    input wire logic clk, // core clock, 200 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic linkClk, // recovered receive clock, sampled
    input wire sgeb_word_t linkWord, // receive word, changes on linkClk fall
    input wire logic rdReq, // core takes one word
    input wire logic statClr, // clears the sticky flags
    output sgeb_word_t rdWord, // word to the core
    output logic rdValid, // rdWord is new this cycle
    output logic ovfFlag, // sticky overflow
    output logic udfFlag, // sticky underflow
    output logic [OCC_W-1:0] occupancy, // current fill level
    output logic primed // forwarding has started
);
    localparam logic [OCC_W-1:0] DEPTH = USE_SMALL ? OCC_W'(DEPTH_SMALL) : OCC_W'(DEPTH_LARGE);
    localparam logic [OCC_W-1:0] HALF = DEPTH >> 1;
    localparam logic [OCC_W-1:0] OVER_LVL = DEPTH - OCC_W'(OVER_GAP);
    localparam logic [OCC_W-1:0] UNDER_LVL = OCC_W'(UNDER_TH);
    localparam logic [PTR_W-1:0] LAST_ADDR = PTR_W'(DEPTH - 8'h01);

    typedef struct packed {
        logic clkS1;
        logic clkS2;
        logic clkS3;
        sgeb_word_t wS1;
        sgeb_word_t wS2;
        sgeb_wr_t wrSt;
        logic inFrame;
        logic [PTR_W-1:0] wrPtr;
        logic [PTR_W-1:0] rdPtr;
        logic [OCC_W-1:0] occ;
        logic primed;
        sgeb_rd_t rdSt;
        sgeb_word_t outWord;
        logic outValid;
        logic [7:0] idleD;
        logic pendErr;
        logic ovf;
        logic udf;
    } sgeb_state_t;

    sgeb_state_t st_r;
    sgeb_state_t st_nxt;
    sgeb_word_t ramQ;
    logic push;
    logic pop;
    logic dropIdle;
    logic dropOvf;
    logic insIdle;
    logic readUdf;
    logic linkEdge;
    logic isComma;
    logic isStart;
    logic isTerm;
    logic headComma;

    assign linkEdge = st_r.clkS2 && !st_r.clkS3;
    assign isComma = st_r.wS2.isK && st_r.wS2.data == SYM_COMMA;
    assign isStart = st_r.wS2.isK && st_r.wS2.data == SYM_START;
    assign isTerm = st_r.wS2.isK && st_r.wS2.data == SYM_TERM;
    assign headComma = ramQ.isK && ramQ.data == SYM_COMMA;

    always_comb
    begin
        st_nxt = st_r;
        push = 1'b0;
        pop = 1'b0;
        dropIdle = 1'b0;
        dropOvf = 1'b0;
        insIdle = 1'b0;
        readUdf = 1'b0;
        st_nxt.clkS1 = linkClk;
        st_nxt.clkS2 = st_r.clkS1;
        st_nxt.clkS3 = st_r.clkS2;
        st_nxt.wS1 = linkWord;
        st_nxt.wS2 = st_r.wS1;
        st_nxt.outValid = 1'b0;

        // write side: one word per recovered clock rising edge
        if (linkEdge)
        begin
            if (isStart)
            begin
                st_nxt.inFrame = 1'b1;
            end
            else if (isTerm)
            begin
                st_nxt.inFrame = 1'b0;
            end
            unique case (st_r.wrSt)
                SGEB_WR_SKIP:
                begin
                    dropIdle = 1'b1;
                    st_nxt.wrSt = SGEB_WR_PASS;
                end
                SGEB_WR_PASS:
                begin
                    if (!st_r.inFrame && isComma && st_r.occ > HALF)
                    begin
                        dropIdle = 1'b1;
                        st_nxt.wrSt = SGEB_WR_SKIP;
                    end
                    else if (st_r.occ >= OVER_LVL)
                    begin
                        dropOvf = 1'b1;
                    end
                    else
                    begin
                        push = 1'b1;
                    end
                end
            endcase
        end

        // read side: paced by the core
        if (rdReq)
        begin
            st_nxt.outValid = 1'b1;
            unique case (st_r.rdSt)
                SGEB_RD_INS:
                begin
                    st_nxt.outWord = '{data: st_r.idleD, isK: 1'b0, err: 1'b0};
                    st_nxt.rdSt = SGEB_RD_HEAD;
                end
                SGEB_RD_HEAD:
                begin
                    if (!st_r.primed || (headComma && st_r.occ < HALF))
                    begin
                        insIdle = 1'b1;
                        st_nxt.outWord = '{data: SYM_COMMA, isK: 1'b1, err: 1'b0};
                        st_nxt.rdSt = SGEB_RD_INS;
                    end
                    else if (st_r.occ < UNDER_LVL)
                    begin
                        readUdf = 1'b1;
                        st_nxt.outWord = '{data: ramQ.data, isK: ramQ.isK, err: 1'b1};
                    end
                    else
                    begin
                        pop = 1'b1;
                        st_nxt.outWord = '{data: ramQ.data, isK: ramQ.isK, err: ramQ.err | st_r.pendErr};
                        st_nxt.pendErr = 1'b0;
                    end
                end
            endcase
        end

        if (push)
        begin
            st_nxt.wrPtr = (st_r.wrPtr == LAST_ADDR) ? '0 : st_r.wrPtr + PTR_W'(1);
        end
        if (pop)
        begin
            st_nxt.rdPtr = (st_r.rdPtr == LAST_ADDR) ? '0 : st_r.rdPtr + PTR_W'(1);
            if (headComma)
            begin
                st_nxt.idleD = SYM_IDLE_D;
            end
        end
        // a push and a pop together leave the level unchanged
        st_nxt.occ = st_r.occ + OCC_W'(push) - OCC_W'(pop);
        if (st_r.occ >= HALF)
        begin
            st_nxt.primed = 1'b1;
        end
        if (statClr)
        begin
            st_nxt.ovf = 1'b0;
            st_nxt.udf = 1'b0;
        end
        if (dropOvf)
        begin
            st_nxt.ovf = 1'b1;
            st_nxt.pendErr = 1'b1;
        end
        if (readUdf)
        begin
            st_nxt.udf = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= '{wrSt: SGEB_WR_PASS, rdSt: SGEB_RD_HEAD, idleD: SYM_IDLE_D, default: '0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    sgeb_ram u_ram (
        .clk(clk),
        .wrEn(push),
        .wrAddr(st_r.wrPtr),
        .wrData(st_r.wS2),
        .rdAddr(st_nxt.rdPtr),
        .rdData(ramQ)
    );

    assign rdWord = st_r.outWord;
    assign rdValid = st_r.outValid;
    assign ovfFlag = st_r.ovf;
    assign udfFlag = st_r.udf;
    assign occupancy = st_r.occ;
    assign primed = st_r.primed;

    // checks
    property p_small_depth;
        @(posedge clk) disable iff (!arst_n) USE_SMALL |-> DEPTH == OCC_W'(DEPTH_SMALL);
    endproperty
    a_small_depth: assert property (p_small_depth) else $error("small depth wrong");

    property p_large_depth;
        @(posedge clk) disable iff (!arst_n) !USE_SMALL |-> DEPTH == OCC_W'(2 * DEPTH_SMALL) && st_r.occ <= DEPTH;
    endproperty
    a_large_depth: assert property (p_large_depth) else $error("large depth or level wrong");

    property p_no_frame_drop;
        @(posedge clk) disable iff (!arst_n) dropIdle && st_r.wrSt == SGEB_WR_PASS |-> !st_r.inFrame && isComma;
    endproperty
    a_no_frame_drop: assert property (p_no_frame_drop) else $error("frame data dropped");

    property p_rise;
        @(posedge clk) disable iff (!arst_n) push && !pop |=> st_r.occ == $past(st_r.occ) + OCC_W'(1);
    endproperty
    a_rise: assert property (p_rise) else $error("level did not rise on write");

    property p_drop_above_half;
        @(posedge clk) disable iff (!arst_n) dropIdle && st_r.wrSt == SGEB_WR_PASS |-> st_r.occ > HALF;
    endproperty
    a_drop_above_half: assert property (p_drop_above_half) else $error("idle dropped below half");

    property p_slip;
        @(posedge clk) disable iff (!arst_n) SLIP_BYTES_WIDE == 5000 && FRAME_CYC_100M == 15220;
    endproperty
    a_slip: assert property (p_slip) else $error("slip rate wrong");

    property p_headroom;
        @(posedge clk) disable iff (!arst_n)
            !USE_SMALL |-> HEADROOM_10M == 31 && HALF - UNDER_LVL >= OCC_W'(HEADROOM_10M)
            && OVER_LVL - HALF >= OCC_W'(HEADROOM_10M);
    endproperty
    a_headroom: assert property (p_headroom) else $error("headroom short");

    property p_narrow;
        @(posedge clk) disable iff (!arst_n)
            HEADROOM_NARROW == 16 && OCC_W'(DEPTH_SMALL / 2 - UNDER_TH) >= OCC_W'(HEADROOM_NARROW);
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow headroom short");

    property p_steady;
        @(posedge clk) disable iff (!arst_n) push && pop |=> $stable(st_r.occ);
    endproperty
    a_steady: assert property (p_steady) else $error("level moved on balanced traffic");

    property p_prime;
        @(posedge clk) disable iff (!arst_n) !st_r.primed |-> !pop;
    endproperty
    a_prime: assert property (p_prime) else $error("forwarded before half full");

    property p_ovf;
        @(posedge clk) disable iff (!arst_n) dropOvf |=> ovfFlag && st_r.pendErr;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_udf;
        @(posedge clk) disable iff (!arst_n) readUdf |=> rdValid && rdWord.err && udfFlag;
    endproperty
    a_udf: assert property (p_udf) else $error("underflow not marked");

    property p_ins;
        @(posedge clk) disable iff (!arst_n) insIdle |=> rdValid && rdWord.isK && rdWord.data == SYM_COMMA;
    endproperty
    a_ins: assert property (p_ins) else $error("inserted idle wrong");

    property p_cov_drop;
        @(posedge clk) disable iff (!arst_n) dropIdle;
    endproperty
    c_cov_drop: cover property (p_cov_drop);

    property p_cov_ins;
        @(posedge clk) disable iff (!arst_n) insIdle && st_r.primed;
    endproperty
    c_cov_ins: cover property (p_cov_ins);

    property p_cov_prime;
        @(posedge clk) disable iff (!arst_n) $rose(st_r.primed);
    endproperty
    c_cov_prime: cover property (p_cov_prime);

    property p_cov_frame;
        @(posedge clk) disable iff (!arst_n) $fell(st_r.inFrame);
    endproperty
    c_cov_frame: cover property (p_cov_frame);
endmodule

// ===== sgeb_pkg.sv
// constants and types for the receive elastic buffer
package sgeb_pkg;
    localparam int DEPTH_SMALL = 64;
    localparam int DEPTH_LARGE = 2 * DEPTH_SMALL;
    localparam int PTR_W = 7;
    localparam int OCC_W = 8;
    localparam int PPM_SCALE = 1000000;
    localparam int PPM_WIDE = 200;
    localparam int PPM_NARROW = 100;
    localparam int SLIP_BYTES_WIDE = PPM_SCALE / PPM_WIDE;
    localparam int SLIP_BYTES_NARROW = PPM_SCALE / PPM_NARROW;
    localparam int MAX_FRAME = 1522;
    localparam int REP_10M = 100;
    localparam int REP_100M = 10;
    localparam int FRAME_CYC_10M = MAX_FRAME * REP_10M;
    localparam int FRAME_CYC_100M = MAX_FRAME * REP_100M;
    localparam int HEADROOM_10M = (FRAME_CYC_10M + SLIP_BYTES_WIDE - 1) / SLIP_BYTES_WIDE;
    localparam int HEADROOM_NARROW = (FRAME_CYC_10M + SLIP_BYTES_NARROW - 1) / SLIP_BYTES_NARROW;
    localparam int UNDER_TH = 2;
    localparam int OVER_GAP = 2;
    localparam logic [7:0] SYM_COMMA = 8'hbc;
    localparam logic [7:0] SYM_START = 8'hfb;
    localparam logic [7:0] SYM_TERM = 8'hfd;
    localparam logic [7:0] SYM_IDLE_D = 8'h50;

    typedef struct packed {
        logic [7:0] data;
        logic isK;
        logic err;
    } sgeb_word_t;

    localparam int WORD_W = $bits(sgeb_word_t);

    typedef enum logic {SGEB_WR_PASS, SGEB_WR_SKIP} sgeb_wr_t;
    typedef enum logic {SGEB_RD_HEAD, SGEB_RD_INS} sgeb_rd_t;
endpackage

// ===== sgeb_ram.sv
// dual-port storage for the elastic buffer, registered read data
`timescale 1ns/100ps
module sgeb_ram
    import sgeb_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic wrEn, // write strobe
    input wire logic [PTR_W-1:0] wrAddr, // write address
    input wire sgeb_word_t wrData, // write word
    input wire logic [PTR_W-1:0] rdAddr, // read address
    output sgeb_word_t rdData // registered read word
);
    sgeb_word_t mem [DEPTH_LARGE];

    always_ff @(posedge clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// ===== sgeb_link_model.sv
// link-side model: free recovered clock and idle or frame words
`timescale 1ns/100ps
module sgeb_link_model
    import sgeb_pkg::*;
#(
    parameter realtime HALF = 32.0 // half link period in ns
)
(
    output logic linkClk, // recovered clock
    output sgeb_word_t linkWord // word, moves on falling edge
);
    int pendLen = 0;
    int idx = 0;
    bit busy = 1'b0;
    bit pairD = 1'b0;
    task automatic send_frame(input int len);
        pendLen = len;
        idx = -1;
        busy = 1'b1;
        wait (!busy);
    endtask
    initial
    begin
        linkClk = 1'b0;
        linkWord = '{SYM_COMMA, 1'b1, 1'b0};
        pairD = 1'b1;
        forever
        begin
            #(HALF) linkClk = 1'b1;
            #(HALF) linkClk = 1'b0;
            // frames start only on a pair boundary
            if (pairD)
                linkWord = '{SYM_IDLE_D, 1'b0, 1'b0};
            else if (!busy)
                linkWord = '{SYM_COMMA, 1'b1, 1'b0};
            else if (idx < 0)
                linkWord = '{SYM_START, 1'b1, 1'b0};
            else if (idx < pendLen)
                linkWord = '{idx[7:0], 1'b0, 1'b0};
            else
                linkWord = '{SYM_TERM, 1'b1, 1'b0};
            // idx advances on frame words only, so the start word is never skipped
            if (busy && !pairD)
                idx = idx + 1;
            pairD = !pairD && !busy;
            if (busy && idx > pendLen)
                busy = 1'b0;
        end
    end
endmodule

// ===== test_sgeb_elastic.sv
// self-checking bench for the receive elastic buffer
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin mismatches++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_sgeb_elastic
    import sgeb_pkg::*;
;
    localparam int HL = DEPTH_LARGE / 2;
    localparam int HS = DEPTH_SMALL / 2;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic rdReq = 1'b0;
    logic statClr = 1'b0;
    logic linkClk;
    logic rdValid;
    logic ovfFlag;
    logic udfFlag;
    logic primed;
    logic ovfS;
    logic [OCC_W-1:0] occupancy;
    logic [OCC_W-1:0] occS;
    logic [2:0] lsync = 3'h0;
    sgeb_word_t linkWord;
    sgeb_word_t rdWord;
    sgeb_word_t lastW;
    sgeb_word_t prevW;
    int mismatches = 0;
    int check_count = 0;
    int mode = 0;
    int cycles = 0;
    int errSeen = 0;
    int expIdx = 0;
    int frameLen = 0;
    int framesOk = 0;
    int e0 = 0;
    bit inF = 1'b0;
    bit monOn = 1'b0;

    sgeb_link_model u_link (.linkClk(linkClk), .linkWord(linkWord));
    sgeb_elastic u_dut (.clk(clk), .arst_n(arst_n), .linkClk(linkClk), .linkWord(linkWord), .rdReq(rdReq),
        .statClr(statClr), .rdWord(rdWord), .rdValid(rdValid), .ovfFlag(ovfFlag), .udfFlag(udfFlag),
        .occupancy(occupancy), .primed(primed));
    sgeb_elastic #(.USE_SMALL(1'b1)) u_small (.clk(clk), .arst_n(arst_n), .linkClk(linkClk),
        .linkWord(linkWord), .rdReq(1'b0), .statClr(statClr), .rdWord(), .rdValid(), .ovfFlag(ovfS),
        .udfFlag(), .occupancy(occS), .primed());

    initial
    begin
        forever
            #2.5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // paced reads follow link edges; frame contents checked on the fly
    always @(posedge clk)
    begin
        lsync <= {lsync[1:0], linkClk};
        rdReq <= (mode == 2) || (mode == 1 && lsync[1] && !lsync[2]);
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            mismatches++;
            end_of_test();
        end
        if (rdValid)
        begin
            prevW <= lastW;
            lastW <= rdWord;
            if (rdWord.err)
                errSeen++;
            if (monOn && rdWord.isK && rdWord.data == SYM_START)
            begin
                inF <= 1'b1;
                expIdx <= 0;
            end
            else if (monOn && inF && rdWord.isK)
            begin
                inF <= 1'b0;
                framesOk <= framesOk + 1;
                `CHK("frame length", frameLen, expIdx)
            end
            else if (monOn && inF)
            begin
                `CHK("frame word", sgeb_word_t'{expIdx[7:0], 1'b0, 1'b0}, rdWord)
                expIdx <= expIdx + 1;
            end
        end
    end

    task automatic wait_lvl(input int lo, input int hi, input int lim);
        for (int n = 0; n < lim && !(occupancy >= lo && occupancy <= hi); n++)
            @(negedge clk);
    endtask

    task automatic chk_lvl(input string nm, input int lo, input int hi);
        `CHK(nm, 1'b1, occupancy >= lo && occupancy <= hi)
    endtask

    task automatic frame(input int len);
        frameLen = len;
        u_link.send_frame(len);
    endtask

    task automatic clr();
        @(posedge clk) statClr <= 1'b1;
        @(posedge clk) statClr <= 1'b0;
        @(negedge clk);
    endtask

    task automatic t_reset();
        `CHK("level in reset", 8'h00, occupancy)
        `CHK("primed in reset", 1'b0, primed)
        @(posedge clk) arst_n <= 1'b1;
        mode <= 2;
        repeat (2) @(posedge clk);
        mode <= 0;
        repeat (6) @(negedge clk);
        `CHK("early comma", sgeb_word_t'{SYM_COMMA, 1'b1, 1'b0}, prevW)
        `CHK("early idle data", sgeb_word_t'{SYM_IDLE_D, 1'b0, 1'b0}, lastW)
        for (int n = 0; n < 3000 && primed !== 1'b1; n++)
            @(negedge clk);
        repeat (40) @(negedge clk);
        `CHK("primed", 1'b1, primed)
        chk_lvl("large half level", HL, HL + 2);
        `CHK("small half level", 1'b1, occS >= HS && occS <= HS + 2)
        $display("reset test done");
    endtask

    task automatic t_shared();
        @(posedge clk) mode <= 1;
        monOn <= 1'b1;
        fork
            frame(200);
            begin
                repeat (1500) @(negedge clk);
                chk_lvl("level mid frame", HL - 3, HL + 3);
            end
        join
        repeat (1200) @(negedge clk);
        chk_lvl("level after frame", HL - 3, HL + 3);
        `CHK("frames intact", 1, framesOk)
        $display("shared clock test done");
    endtask

    task automatic t_fast();
        fork
            frame(100);
            begin
                repeat (100) @(posedge clk);
                mode <= 0;
                repeat (256) @(posedge clk);
                mode <= 1;
                @(negedge clk);
                chk_lvl("level after stall", HL + 17, DEPTH_LARGE - 3);
                `CHK("no overflow", 1'b0, ovfFlag)
            end
        join
        wait_lvl(HL, HL + 2, 5000);
        repeat (1200) @(negedge clk);
        // pair deletion may stop one entry below half
        chk_lvl("gap trims level", HL - 1, HL + 2);
        `CHK("frame kept", 2, framesOk)
        $display("fast write test done");
    endtask

    task automatic t_ovf();
        @(posedge clk) mode <= 0;
        monOn <= 1'b0;
        frame(100);
        @(negedge clk);
        `CHK("overflow flag", 1'b1, ovfFlag)
        `CHK("small overflow flag", 1'b1, ovfS)
        `CHK("full level", DEPTH_LARGE - 2, occupancy)
        `CHK("small full level", DEPTH_SMALL - 2, occS)
        // let the dropped terminator land before clearing
        repeat (40) @(negedge clk);
        clr();
        `CHK("overflow cleared", 1'b0, ovfFlag)
        e0 = errSeen;
        @(posedge clk) mode <= 1;
        wait_lvl(HL, HL + 2, 5000);
        chk_lvl("drained to half", HL, HL + 2);
        `CHK("errored after overflow", 1'b1, errSeen > e0)
        `CHK("overflow stays clear", 1'b0, ovfFlag)
        $display("overflow test done");
    endtask

    task automatic t_udf();
        e0 = errSeen;
        fork
            frame(150);
            begin
                repeat (60) @(posedge clk);
                mode <= 2;
                for (int n = 0; n < 2000 && udfFlag !== 1'b1; n++)
                    @(negedge clk);
                @(posedge clk) mode <= 1;
            end
        join
        `CHK("underflow flag", 1'b1, udfFlag)
        `CHK("errored after underflow", 1'b1, errSeen > e0)
        wait_lvl(HL, HL + 2, 5000);
        clr();
        `CHK("underflow cleared", 1'b0, udfFlag)
        chk_lvl("refilled to half", HL - 1, HL + 2);
        $display("underflow test done");
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        t_reset();
        t_shared();
        t_fast();
        t_ovf();
        t_udf();
        end_of_test();
    end
endmodule
